// ### rtl/hsp_serial_port.sv
// Operation
// R1: mode pin high selects three-wire, low selects two-wire operation.
// R2: three-wire reads shift each bit out on the serial output at falling clock.
// R3: three-wire writes capture the input line on rising clock edges.
// R4: three-wire serial output shows 1 in control and write mode, data when reading.
// R5: two-wire reads turn the shared line to output, bits on falling clock.
// R6: two-wire writes and control keep the shared line input, sampled on rising clock.
// R7: two-wire mode keeps the dedicated serial output in high impedance.
// R8: reset or deselect: shared line input, serial output high impedance.
// R9: command select high is control mode; its byte gives address and direction.
// R10: after reset the port is set for a write to address zero.
// R11: control bytes need eight clocks; shorter fragments are discarded.
// R12: after a read selection, command select low reads register bits on falling clocks.
// R13: command select rising during a read clears the counter; receive fifo advances.
// R14: after a write selection, command select low samples write data on rising clocks.
// R15: the target register updates at the eighth rising edge; partial bytes ignored.
// R16: host must not drive the shared line while the port drives it.
// R17: a build parameter picks msb-first or lsb-first for every byte.
// R18: in standby only control register writes and flag register reads are allowed.
`timescale 1ns/1ns
`default_nettype none
module hsp_serial_port #(
  parameter bit MSB_FIRST = 1'b1
) (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  // host pins
  input wire logic SCK_I,
  input wire logic CS_N_I,
  input wire logic CMD_SEL_I,
  input wire logic MODE_SEL_I,
  input wire logic SHARED_DATA_LINE_I,
  output logic SHARED_DATA_LINE_O,
  output logic SHARED_DATA_LINE_OE_O,
  output logic SER_OUT_O,
  output logic SER_OUT_OE_O,
  // register side
  input wire logic STANDBY_I,
  input wire logic [hsp_pkg::BYTE_W-1:0] RD_DATA_I,
  output logic [hsp_pkg::ADDR_W-1:0] RD_ADDR_O,
  output logic RD_POP_O,
  output hsp_pkg::hsp_wr_s WR_O
);

  // bit index of the cnt-th bit on the wire
  function automatic logic [hsp_pkg::CNT_W-1:0] wire_idx(input logic [hsp_pkg::CNT_W-1:0] cnt);
    wire_idx = MSB_FIRST ? (hsp_pkg::CNT_LAST - cnt) : cnt; // [R17]
  endfunction : wire_idx

  // shift one received bit into a partial byte
  function automatic logic [hsp_pkg::BYTE_W-1:0] shift_in(input logic [hsp_pkg::BYTE_W-1:0] b, input logic d);
    shift_in = MSB_FIRST ? {b[hsp_pkg::BYTE_W-2:0], d} : {d, b[hsp_pkg::BYTE_W-1:1]}; // [R17]
  endfunction : shift_in

  logic [hsp_pkg::PIN_N-1:0] pin_vec;
  logic [hsp_pkg::PIN_N-1:0] s1_ff;
  logic [hsp_pkg::PIN_N-1:0] s2_ff;
  logic [hsp_pkg::PIN_N-1:0] s3_ff;
  logic [hsp_pkg::PIN_N-1:0] flt_ff;
  logic [hsp_pkg::PIN_N-1:0] prev_ff;
  logic rise;
  logic fall;
  logic cmd_edge;
  logic active;
  logic sel_f;
  logic din_f;
  hsp_pkg::hsp_st_e st_ff;
  hsp_pkg::hsp_st_e nxt_st;
  logic [hsp_pkg::CNT_W-1:0] cnt_ff;
  logic [hsp_pkg::BYTE_W-1:0] sh_ff;
  logic [hsp_pkg::BYTE_W-1:0] byte_now;
  logic [hsp_pkg::ADDR_W-1:0] addr_ff;
  logic rd_sel_ff;
  logic last_rise;
  logic rd_ok;
  logic wr_ok;
  logic [hsp_pkg::BYTE_W-1:0] rd_byte;
  logic [hsp_pkg::BYTE_W-1:0] out_byte_ff;
  logic out_bit_ff;

  assign pin_vec = {SHARED_DATA_LINE_I, MODE_SEL_I, CMD_SEL_I, CS_N_I, SCK_I};

  // three-stage sync; a level counts once stages two and three agree
  for (genvar g = 0; g < hsp_pkg::PIN_N; g++) begin : g_sync
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
        s1_ff[g] <= hsp_pkg::PIN_IDLE[g];
        s2_ff[g] <= hsp_pkg::PIN_IDLE[g];
        s3_ff[g] <= hsp_pkg::PIN_IDLE[g];
        flt_ff[g] <= hsp_pkg::PIN_IDLE[g];
        prev_ff[g] <= hsp_pkg::PIN_IDLE[g];
      end else begin
        s1_ff[g] <= pin_vec[g];
        s2_ff[g] <= s1_ff[g];
        s3_ff[g] <= s2_ff[g];
        if (s2_ff[g] == s3_ff[g]) begin
          flt_ff[g] <= s3_ff[g];
        end
        prev_ff[g] <= flt_ff[g];
      end
    end
  end

  // edges of the filtered host pins
  assign rise = flt_ff[hsp_pkg::PIN_SCK] & ~prev_ff[hsp_pkg::PIN_SCK];
  assign fall = ~flt_ff[hsp_pkg::PIN_SCK] & prev_ff[hsp_pkg::PIN_SCK];
  assign cmd_edge = flt_ff[hsp_pkg::PIN_CMD] ^ prev_ff[hsp_pkg::PIN_CMD];
  assign active = ~flt_ff[hsp_pkg::PIN_CS];
  assign sel_f = flt_ff[hsp_pkg::PIN_SEL]; // [R1]
  assign din_f = flt_ff[hsp_pkg::PIN_DIN];
  assign byte_now = shift_in(sh_ff, din_f);
  assign last_rise = active && rise && !cmd_edge && (st_ff != hsp_pkg::ST_READ) && (cnt_ff == hsp_pkg::CNT_LAST);

  // standby lets only control register writes and flag register reads through
  assign wr_ok = !STANDBY_I || (addr_ff == hsp_pkg::ADDR_CONTROL_REGISTER); // [R18]
  assign rd_ok = !STANDBY_I || (addr_ff == hsp_pkg::ADDR_FLAG_REGISTER); // [R18]
  assign rd_byte = rd_ok ? RD_DATA_I : hsp_pkg::STBY_FILL;

  // phase follows command select and the last direction chosen
  always_comb begin
    if (flt_ff[hsp_pkg::PIN_CMD]) begin
      nxt_st = hsp_pkg::ST_CTRL; // [R9]
    end else if (rd_sel_ff) begin
      nxt_st = hsp_pkg::ST_READ; // [R12]
    end else begin
      nxt_st = hsp_pkg::ST_WRITE; // [R14]
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_ff <= hsp_pkg::ST_CTRL;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // bit counter; any command select change drops a partial byte
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cnt_ff <= hsp_pkg::CNT_ZERO;
    end else if (!active || cmd_edge) begin
      cnt_ff <= hsp_pkg::CNT_ZERO; // [R11] [R13] [R15]
    end else if ((st_ff == hsp_pkg::ST_READ) ? fall : rise) begin
      cnt_ff <= cnt_ff + hsp_pkg::CNT_ONE; // wraps after eight bits
    end
  end

  // input shifter, rising edges in control and write phases
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sh_ff <= '0;
    end else if (active && rise && st_ff != hsp_pkg::ST_READ) begin
      sh_ff <= byte_now; // [R3] [R6]
    end
  end

  // control byte: address and direction; reset leaves a write to address zero
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      addr_ff <= hsp_pkg::ADDR_CONTROL_REGISTER; // [R10]
      rd_sel_ff <= 1'b0; // [R10]
    end else if (last_rise && st_ff == hsp_pkg::ST_CTRL) begin
      addr_ff <= byte_now[hsp_pkg::CTL_ADDR_LSB +: hsp_pkg::ADDR_W]; // [R9] [R11]
      rd_sel_ff <= byte_now[hsp_pkg::CTL_RD_BIT];
    end
  end

  // register write at the eighth rising edge; fifo consumer acts on the pulse after it
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      WR_O <= '0;
    end else begin
      WR_O.valid <= last_rise && (st_ff == hsp_pkg::ST_WRITE) && wr_ok; // [R15]
      WR_O.addr <= addr_ff;
      WR_O.data <= byte_now;
    end
  end

  // read shifter: a byte loads on its first falling edge, so a cut-short
  // receive fifo byte is already popped and the next read takes the next one
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      out_byte_ff <= '0;
      out_bit_ff <= 1'b1;
      RD_POP_O <= 1'b0;
    end else begin
      RD_POP_O <= 1'b0;
      if (active && fall && !cmd_edge && st_ff == hsp_pkg::ST_READ) begin
        if (cnt_ff == hsp_pkg::CNT_ZERO) begin
          out_byte_ff <= rd_byte;
          out_bit_ff <= rd_byte[wire_idx(cnt_ff)]; // [R2] [R5] [R12]
          RD_POP_O <= rd_ok && (addr_ff == hsp_pkg::ADDR_RECEIVE_FIFO); // [R13]
        end else begin
          out_bit_ff <= out_byte_ff[wire_idx(cnt_ff)]; // [R2] [R5]
        end
      end
    end
  end

  // read address toward the register file
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RD_ADDR_O <= hsp_pkg::ADDR_CONTROL_REGISTER;
    end else begin
      RD_ADDR_O <= addr_ff;
    end
  end

  // pin drivers; the host must keep off the shared line while its enable is high
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      SER_OUT_O <= 1'b1;
      SER_OUT_OE_O <= 1'b0; // [R8]
      SHARED_DATA_LINE_O <= 1'b1;
      SHARED_DATA_LINE_OE_O <= 1'b0; // [R8]
    end else begin
      SER_OUT_OE_O <= active && sel_f; // [R1] [R7] [R8]
      SER_OUT_O <= (st_ff == hsp_pkg::ST_READ) ? out_bit_ff : 1'b1; // [R4]
      SHARED_DATA_LINE_OE_O <= active && !sel_f && (st_ff == hsp_pkg::ST_READ); // [R5] [R6] [R16]
      SHARED_DATA_LINE_O <= out_bit_ff;
    end
  end

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);

  sequence s_eighth_ctrl;
    last_rise && st_ff == hsp_pkg::ST_CTRL;
  endsequence
  sequence s_eighth_write;
    last_rise && st_ff == hsp_pkg::ST_WRITE && wr_ok;
  endsequence

  property p_three_wire_on;
    (active && sel_f) |=> SER_OUT_OE_O;
  endproperty
  a_three_wire_on: assert property (p_three_wire_on) else $error("serial output not enabled in three-wire mode"); // [R1]

  property p_out_one;
    (active && sel_f && st_ff != hsp_pkg::ST_READ) |=> SER_OUT_O;
  endproperty
  a_out_one: assert property (p_out_one) else $error("serial output not 1 outside read mode"); // [R4]

  property p_read_bit;
    (active && fall && !cmd_edge && st_ff == hsp_pkg::ST_READ && cnt_ff != hsp_pkg::CNT_ZERO)
      |=> out_bit_ff == out_byte_ff[wire_idx($past(cnt_ff))];
  endproperty
  a_read_bit: assert property (p_read_bit) else $error("read bit not taken on falling edge"); // [R2]

  property p_two_wire_drive;
    SHARED_DATA_LINE_OE_O |-> $past(!sel_f && active && st_ff == hsp_pkg::ST_READ);
  endproperty
  a_two_wire_drive: assert property (p_two_wire_drive) else $error("shared line driven outside read"); // [R5]

  property p_two_wire_hiz;
    !sel_f |=> !SER_OUT_OE_O;
  endproperty
  a_two_wire_hiz: assert property (p_two_wire_hiz) else $error("serial output driven in two-wire mode"); // [R7]

  property p_deselect;
    !active |=> (!SER_OUT_OE_O && !SHARED_DATA_LINE_OE_O);
  endproperty
  a_deselect: assert property (p_deselect) else $error("pin driven while deselected"); // [R8]

  property p_ctrl_byte;
    s_eighth_ctrl |=> (addr_ff == $past(byte_now[hsp_pkg::CTL_ADDR_LSB +: hsp_pkg::ADDR_W])) && cnt_ff == hsp_pkg::CNT_ZERO;
  endproperty
  a_ctrl_byte: assert property (p_ctrl_byte) else $error("control byte not taken at eighth clock"); // [R11]

  property p_write_pulse;
    s_eighth_write |=> WR_O.valid ##1 !WR_O.valid;
  endproperty
  a_write_pulse: assert property (p_write_pulse) else $error("write pulse missing or too long"); // [R15]

  property p_write_cause;
    WR_O.valid |-> $past(last_rise && st_ff == hsp_pkg::ST_WRITE);
  endproperty
  a_write_cause: assert property (p_write_cause) else $error("write without eighth rising edge"); // [R15]

  property p_cmd_clear;
    (active && cmd_edge) |=> cnt_ff == hsp_pkg::CNT_ZERO;
  endproperty
  a_cmd_clear: assert property (p_cmd_clear) else $error("bit counter not cleared on command change"); // [R13]

  property p_standby_write;
    (STANDBY_I && addr_ff != hsp_pkg::ADDR_CONTROL_REGISTER) |=> !WR_O.valid;
  endproperty
  a_standby_write: assert property (p_standby_write) else $error("write allowed in standby"); // [R18]

endmodule : hsp_serial_port
`default_nettype wire

// ### rtl/hsp_pkg.sv
`default_nettype none
package hsp_pkg;
  // widths
  localparam int ADDR_W = 4;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 3;
  // bit counter figures
  localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
  localparam logic [CNT_W-1:0] CNT_LAST = 3'h7;
  // register addresses seen by this port
  localparam logic [ADDR_W-1:0] ADDR_CONTROL_REGISTER = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_FLAG_REGISTER = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_RECEIVE_FIFO = 4'hE;
  localparam logic [ADDR_W-1:0] ADDR_TRANSMIT_FIFO = 4'hE;
  // control byte layout: address in the low nibble, read select above it
  localparam int CTL_ADDR_LSB = 0;
  localparam int CTL_RD_BIT = 4;
  // byte shown for a read that standby forbids
  localparam logic [BYTE_W-1:0] STBY_FILL = 8'hFF;
  // synchronised pin vector layout and idle levels
  localparam int PIN_N = 5;
  localparam int PIN_SCK = 0;
  localparam int PIN_CS = 1;
  localparam int PIN_CMD = 2;
  localparam int PIN_SEL = 3;
  localparam int PIN_DIN = 4;
  localparam logic [PIN_N-1:0] PIN_IDLE = 5'h1F;

  // transfer phases, one-hot
  typedef enum logic [2:0] {
    ST_CTRL = 3'h1,
    ST_WRITE = 3'h2,
    ST_READ = 3'h4
  } hsp_st_e;

  // one completed register write
  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] data;
  } hsp_wr_s;
endpackage : hsp_pkg
`default_nettype wire

// ### verif/hsp_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module hsp_host_model (
  // clock and device pins
  input wire logic clk_i,
  input wire logic mode_i,
  input wire logic so_i,
  input wire logic so_oe_i,
  input wire logic sh_i,
  input wire logic sh_oe_i,
  // host pins
  output logic sck_o,
  output logic cs_n_o,
  output logic cmd_o,
  output logic din_o
);
  logic hd = 1'b1;
  logic hoe = 1'b0;
  logic last = 1'b0;
  // shared line: host alone in three-wire; in two-wire device first, then host, else the pull-up
  assign din_o = mode_i ? hd : (sh_oe_i ? sh_i : (hoe ? hd : 1'b1));
  // pins idle high
  initial begin
    sck_o = 1'b1;
    cs_n_o = 1'b1;
    cmd_o = 1'b1;
  end
  // chip select change, then settle time
  task automatic sel(input logic v);
    @(negedge clk_i);
    cs_n_o = v;
    repeat (10) @(negedge clk_i);
  endtask : sel
  // n bits msb first; low phase is long so a slow read bit is still caught
  task automatic xfer(input logic c, input logic rd, input logic [7:0] tx, input int n, output logic [7:0] rx);
    @(negedge clk_i);
    cmd_o = c;
    repeat (10) @(negedge clk_i);
    hoe = !rd;
    #2;
    rx = 8'h00;
    for (int i = 0; i < n; i++) begin
      sck_o = 1'b0;
      hd = tx[7-i];
      #75;
      last = mode_i ? (so_oe_i ? so_i : ~last) : din_o;
      rx[7-i] = last;
      sck_o = 1'b1;
      #50;
    end
    hoe = 1'b0;
  endtask : xfer
endmodule : hsp_host_model
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  typedef struct packed {logic m; logic rd; logic [3:0] a; logic [7:0] d; logic [7:0] e;} hsp_row_s;
  logic clk;
  logic rst_n = 1'b0;
  logic mode = 1'b1;
  logic stby = 1'b0;
  logic sck, cs_n, cmd, din, sh_o, sh_oe, so, so_oe, pop;
  logic [3:0] ra;
  logic [7:0] rdd;
  logic [7:0] rx;
  logic [7:0] fifo_idx = 8'h00;
  hsp_pkg::hsp_wr_s wr;
  hsp_pkg::hsp_wr_s wq[$];
  int fail_count = 0;
  int check_count = 0;
  hsp_row_s rows [6] = '{'{1'b1, 1'b0, 4'h3, 8'hA5, 8'hFF}, '{1'b0, 1'b0, 4'h5, 8'h3C, 8'h00},
    '{1'b1, 1'b1, 4'h2, 8'h00, 8'h2D}, '{1'b0, 1'b1, 4'h7, 8'h00, 8'h78},
    '{1'b1, 1'b1, 4'hE, 8'h00, 8'hC0}, '{1'b0, 1'b0, 4'hE, 8'h81, 8'h00}};
  // register side stand-in: fifo gives a running count, others a pattern
  assign rdd = (ra == hsp_pkg::ADDR_RECEIVE_FIFO) ? 8'hC0 + fifo_idx : {ra, ~ra};
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // default bit order, msb first
  hsp_serial_port DUT (.REF_CLK_I(clk), .RST_N_I(rst_n), .SCK_I(sck), .CS_N_I(cs_n),
    .CMD_SEL_I(cmd), .MODE_SEL_I(mode), .SHARED_DATA_LINE_I(din), .SHARED_DATA_LINE_O(sh_o),
    .SHARED_DATA_LINE_OE_O(sh_oe), .SER_OUT_O(so), .SER_OUT_OE_O(so_oe), .STANDBY_I(stby),
    .RD_DATA_I(rdd), .RD_ADDR_O(ra), .RD_POP_O(pop), .WR_O(wr));
  hsp_host_model HOST (.clk_i(clk), .mode_i(mode), .so_i(so), .so_oe_i(so_oe), .sh_i(sh_o),
    .sh_oe_i(sh_oe), .sck_o(sck), .cs_n_o(cs_n), .cmd_o(cmd), .din_o(din));
  // pops advance the fifo; writes queue up for checking
  always @(posedge clk) begin
    if (pop) fifo_idx <= fifo_idx + 8'h01;
    if (wr.valid) wq.push_back(wr);
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // bounded wait for one queued write
  task automatic wchk(input logic [3:0] a, input logic [7:0] d);
    hsp_pkg::hsp_wr_s w;
    for (int k = 0; k < 30 && wq.size() == 0; k++) @(negedge clk);
    chk(8'(wq.size()), 8'h01);
    w = (wq.size() > 0) ? wq.pop_front() : '0;
    chk({4'h0, w.addr}, {4'h0, a});
    chk(w.data, d);
  endtask : wchk
  task automatic op(input logic rd, input logic [3:0] a, input logic [7:0] d);
    HOST.xfer(1'b1, 1'b0, {3'h0, rd, a}, 8, rx);
    HOST.xfer(1'b0, rd, d, 8, rx);
  endtask : op
  task automatic stop_test;
    $display("checks=%0d fails=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test
  // hang guard, well beyond the expected run of some 36 us
  initial begin
    #200000;
    fail_count++;
    stop_test();
  end
  initial begin
    repeat (10) @(negedge clk);
    chk({7'h00, so_oe | sh_oe}, 8'h00);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    HOST.sel(1'b0);
    HOST.xfer(1'b0, 1'b0, 8'h5A, 8, rx);
    chk(rx, 8'hFF);
    wchk(4'h0, 8'h5A);
    HOST.sel(1'b1);
    chk({7'h00, so_oe}, 8'h00);
    HOST.sel(1'b0);
    $display("reset test done");
    foreach (rows[i]) begin
      @(negedge clk);
      mode = rows[i].m;
      repeat (10) @(negedge clk);
      op(rows[i].rd, rows[i].a, rows[i].d);
      if (rows[i].rd) chk(rx, rows[i].e);
      else wchk(rows[i].a, rows[i].d);
      if (rows[i].m) chk(rx, rows[i].rd ? rows[i].e : 8'hFF);
      chk({6'h00, so_oe, sh_oe}, {6'h00, rows[i].m, !rows[i].m && rows[i].rd});
      $display("row %0d done", i);
    end
    @(negedge clk);
    mode = 1'b1;
    // read cut short by command select: fifo moves on, others restart
    for (int j = 0; j < 2; j++) begin
      HOST.xfer(1'b1, 1'b0, j ? 8'h12 : 8'h1E, 8, rx);
      HOST.xfer(1'b0, 1'b1, 8'h00, 3, rx);
      HOST.xfer(1'b1, 1'b0, 8'h00, 0, rx);
      HOST.xfer(1'b0, 1'b1, 8'h00, 8, rx);
      chk(rx, j ? 8'h2D : 8'hC2);
    end
    $display("cut read test done");
    // mid-run reset while a read of address 2 is selected: port must fall back to a write of address zero
    @(negedge clk);
    rst_n = 1'b0;
    repeat (10) @(negedge clk);
    chk({6'h00, so_oe, sh_oe}, 8'h00);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    HOST.xfer(1'b0, 1'b0, 8'h3C, 8, rx);
    wchk(4'h0, 8'h3C);
    $display("mid reset test done");
    HOST.xfer(1'b1, 1'b0, 8'h1F, 5, rx);
    HOST.sel(1'b1);
    HOST.sel(1'b0);
    HOST.xfer(1'b1, 1'b0, 8'h04, 8, rx);
    HOST.xfer(1'b0, 1'b0, 8'h99, 3, rx);
    HOST.xfer(1'b1, 1'b0, 8'h00, 0, rx);
    HOST.xfer(1'b0, 1'b0, 8'h66, 8, rx);
    wchk(4'h4, 8'h66);
    $display("fragment test done");
    @(negedge clk);
    stby = 1'b1;
    op(1'b0, 4'h3, 8'h11);
    repeat (30) @(negedge clk);
    chk(8'(wq.size()), 8'h00);
    op(1'b1, 4'h2, 8'h00);
    chk(rx, 8'hFF);
    op(1'b1, 4'h1, 8'h00);
    chk(rx, 8'h1E);
    op(1'b0, 4'h0, 8'h22);
    wchk(4'h0, 8'h22);
    $display("standby test done");
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
